// File: pkg/cmx_pkg.sv
package cmx_pkg;

    localparam int unsigned DATA_W      = 14;
    localparam int unsigned PRESC_W     = 3;
    localparam int unsigned LOCK_WIN_W  = 4;
    localparam int unsigned LOCK_CNT_W  = 4;

    // prescaler select codes and the terminal count of each ratio
    localparam logic [1:0]         SEL_PRESCALER_SEL_HI    = 2'h0;
    localparam logic [1:0]         SEL_DIV2    = 2'h1;
    localparam logic [1:0]         SEL_DIV4    = 2'h2;
    localparam logic [1:0]         SEL_DIV8    = 2'h3;
    localparam logic [PRESC_W-1:0] TERM_PRESCALER_SEL_HI   = 3'h0;
    localparam logic [PRESC_W-1:0] TERM_DIV2   = 3'h1;
    localparam logic [PRESC_W-1:0] TERM_DIV4   = 3'h3;
    localparam logic [PRESC_W-1:0] TERM_DIV8   = 3'h7;

    // lock detector: ref edge must land within LOCK_WIN cycles of a 1x edge,
    // LOCK_HITS times in a row
    localparam logic [LOCK_WIN_W-1:0] LOCK_WIN  = 4'h3;
    localparam logic [LOCK_CNT_W-1:0] LOCK_HITS = 4'h8;
    localparam logic [15:0]           LFSR_SEED = 16'hACE1;
    localparam logic [15:0]           LFSR_TAPS = 16'hB400;

    // reset values
    localparam logic                  RST_CLK1X = 1'b1;
    localparam logic [DATA_W-1:0]     RST_DATA  = 14'h0000;

    typedef struct packed {
        logic       multiplier_en;
        logic       prescaler_sel_hi;
        logic       prescaler_sel_lo;
        logic       zero_stuff_select;
        logic       filter_response_select;
    } cmx_ctrl_t;

    typedef struct packed {
        logic       tick_1x;
        logic       tick_2x;
        logic       tick_4x;
        logic       capture;
    } cmx_ticks_t;

    typedef struct packed {
        logic [PRESC_W-1:0] count;
        logic               tick;
        logic               vco_prev;
    } cmx_presc_state_t;

    typedef struct packed {
        logic                  ref_prev;
        logic                  q4;
        logic                  clk1x;
        logic                  lock_ind;
        logic                  locked;
        logic [LOCK_WIN_W-1:0] since_1x;
        logic [LOCK_CNT_W-1:0] hits;
        logic [15:0]           lfsr;
        cmx_ticks_t            ticks;
        logic [DATA_W-1:0]     sample;
        logic                  filter_hp;
        logic                  zero_stuff;
    } cmx_state_t;

endpackage : cmx_pkg

// File: rtl/cmx_clock_control.sv
`timescale 1ns/1ps
`default_nettype none

module cmx_clock_control (
    input  wire logic                       clk_i,
    input  wire logic                       nrst_i,
    input  wire cmx_pkg::cmx_ctrl_t         ctrl_i,
    input  wire logic                       ref_clk_i,
    input  wire logic                       vco_i,
    input  wire logic                       align_reset_i,
    input  wire logic [cmx_pkg::DATA_W-1:0] data_i,
    output logic                            lock_indicator_o,
    output logic                            locked_o,
    output cmx_pkg::cmx_ticks_t             ticks_o,
    output logic [cmx_pkg::DATA_W-1:0]      sample_o,
    output logic                            filter_hp_o,
    output logic                            zero_stuff_o
);

    cmx_pkg::cmx_state_t state;
    cmx_pkg::cmx_state_t next_state;
    logic                presc_tick;
    logic                ref_rise;
    logic                base_edge;
    logic                edge_2x;
    logic                bypass;

    cmx_prescaler u_presc (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .vco_i  (vco_i),
        .sel_i  ({ctrl_i.prescaler_sel_hi, ctrl_i.prescaler_sel_lo}),
        .tick_o (presc_tick)
    );

    always_comb begin
        bypass   = !ctrl_i.multiplier_en;
        ref_rise = ref_clk_i && !state.ref_prev;
        // fastest clock: prescaled oscillator, or the reference itself in bypass
        base_edge = bypass ? ref_rise : presc_tick;
        // with zero stuffing the base runs at 4x, so every other edge is a 2x edge
        edge_2x = base_edge && (!ctrl_i.zero_stuff_select || state.q4);
    end

    always_comb begin
        next_state            = state;
        next_state.ref_prev   = ref_clk_i;
        next_state.filter_hp  = ctrl_i.filter_response_select;
        next_state.zero_stuff = ctrl_i.zero_stuff_select;
        next_state.ticks      = '0;
        next_state.lfsr       = state.lfsr[0] ? ((state.lfsr >> 1) ^ cmx_pkg::LFSR_TAPS)
                                              : (state.lfsr >> 1);

        if (base_edge) begin
            next_state.q4            = ctrl_i.zero_stuff_select ? !state.q4 : 1'b0;
            next_state.ticks.tick_4x = ctrl_i.zero_stuff_select;
        end

        if (edge_2x) begin
            next_state.clk1x         = !state.clk1x;
            next_state.ticks.tick_2x = 1'b1;
            if (!state.clk1x) begin
                // this edge raises 1x and is the latch edge
                next_state.ticks.tick_1x = 1'b1;
                next_state.ticks.capture = 1'b1;
                next_state.sample        = data_i;
            end
        end

        // bypass alignment: reset parks 1x high and the 4x phase at its start
        if (bypass && align_reset_i) begin
            next_state.clk1x = 1'b1;
            next_state.q4    = 1'b0;
            next_state.ticks = '0;
        end

        // lock detector: reference edges must coincide with divided 1x edges
        if (next_state.ticks.tick_1x) begin
            next_state.since_1x = '0;
        end else if (state.since_1x != '1) begin
            next_state.since_1x = state.since_1x + 4'h1;
        end
        if (bypass) begin
            next_state.hits   = '0;
            next_state.locked = 1'b0;
        end else if (ref_rise) begin
            if (state.since_1x <= cmx_pkg::LOCK_WIN || next_state.ticks.tick_1x) begin
                if (state.hits != cmx_pkg::LOCK_HITS) begin
                    next_state.hits = state.hits + 4'h1;
                end
            end else begin
                next_state.hits = '0;
            end
            next_state.locked = (next_state.hits == cmx_pkg::LOCK_HITS);
        end

        if (bypass) begin
            next_state.lock_ind = next_state.clk1x;
        end else if (next_state.locked) begin
            next_state.lock_ind = 1'b1;
        end else begin
            next_state.lock_ind = state.lfsr[0];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state       <= '0;
            state.clk1x <= cmx_pkg::RST_CLK1X;
            state.lfsr  <= cmx_pkg::LFSR_SEED;
        end else begin
            state <= next_state;
        end
    end

    assign lock_indicator_o = state.lock_ind;
    assign locked_o         = state.locked;
    assign ticks_o          = state.ticks;
    assign sample_o         = state.sample;
    assign filter_hp_o      = state.filter_hp;
    assign zero_stuff_o     = state.zero_stuff;

endmodule : cmx_clock_control

`default_nettype wire

// File: rtl/cmx_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module cmx_prescaler (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       vco_i,
    input  wire logic [1:0] sel_i,
    output logic            tick_o
);

    cmx_pkg::cmx_presc_state_t state;
    cmx_pkg::cmx_presc_state_t next_state;
    logic [cmx_pkg::PRESC_W-1:0] term;

    always_comb begin
        unique case (sel_i)
            cmx_pkg::SEL_PRESCALER_SEL_HI: term = cmx_pkg::TERM_PRESCALER_SEL_HI;
            cmx_pkg::SEL_DIV2: term = cmx_pkg::TERM_DIV2;
            cmx_pkg::SEL_DIV4: term = cmx_pkg::TERM_DIV4;
            cmx_pkg::SEL_DIV8: term = cmx_pkg::TERM_DIV8;
        endcase
    end

    always_comb begin
        next_state          = state;
        next_state.vco_prev = vco_i;
        next_state.tick     = 1'b0;
        if (vco_i && !state.vco_prev) begin
            if (state.count >= term) begin
                next_state.count = '0;
                next_state.tick  = 1'b1;
            end else begin
                next_state.count = state.count + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick_o = state.tick;

endmodule : cmx_prescaler

`default_nettype wire

// File: tb/cmx_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cmx_properties (
    input wire logic                       clk_i,
    input wire logic                       nrst_i,
    input wire cmx_pkg::cmx_ctrl_t         ctrl_i,
    input wire logic                       align_reset_i,
    input wire logic [cmx_pkg::DATA_W-1:0] data_i,
    input wire logic                       lock_indicator_o,
    input wire logic                       locked_o,
    input wire cmx_pkg::cmx_ticks_t        ticks_o,
    input wire logic [cmx_pkg::DATA_W-1:0] sample_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    chk_cap_edges: assert property (ticks_o.capture |-> ticks_o.tick_1x && ticks_o.tick_2x)
        else $error("capture off 1x edge");
    chk_sample_load: assert property (ticks_o.capture |-> sample_o == $past(data_i))
        else $error("sample not loaded");
    chk_sample_hold: assert property (!ticks_o.capture && $past(nrst_i) |-> $stable(sample_o))
        else $error("sample moved");
    chk_pin_1x: assert property ((!ctrl_i.multiplier_en && !align_reset_i) [*3]
        |-> $rose(lock_indicator_o) == ticks_o.capture) else $error("pin not 1x");
    chk_align_force: assert property (!ctrl_i.multiplier_en && align_reset_i
        |=> lock_indicator_o && ticks_o == '0) else $error("align not forced");
    chk_no_4x: assert property (!ctrl_i.zero_stuff_select [*2] |-> !ticks_o.tick_4x)
        else $error("4x without stuffing");
    chk_bypass_unlocked: assert property (!ctrl_i.multiplier_en [*2] |-> !locked_o)
        else $error("locked in bypass");
    chk_lock_pin: assert property (ctrl_i.multiplier_en [*2] ##0 locked_o |-> lock_indicator_o)
        else $error("lock pin low");
endmodule : cmx_properties
bind cmx_clock_control cmx_properties u_props (.clk_i, .nrst_i, .ctrl_i, .align_reset_i, .data_i,
    .lock_indicator_o, .locked_o, .ticks_o, .sample_o);
`default_nettype wire

// File: tb/cmx_source.sv
`timescale 1ns/1ps
`default_nettype none
module cmx_source (
    input  wire logic                       clk_i,
    input  wire logic                       ref_run_i,
    input  wire logic                       vco_run_i,
    output logic                            ref_clk_o = 1'h0,
    output logic                            vco_o = 1'h0,
    output logic [cmx_pkg::DATA_W-1:0]      data_o = 14'h1234
);
    logic [1:0] ph = 2'h0;
    // reference stands low outside runs; data moves on the falling half only
    always @(posedge clk_i) begin
        ph        <= ph + 2'h1;
        ref_clk_o <= ref_run_i & ph[1];
        // oscillator runs at twice the reference rate so that a 1x divide can lock
        vco_o     <= vco_run_i & ph[0];
        if (ref_clk_o && !ph[1]) begin
            data_o <= data_o + 14'h0001;
        end
    end
endmodule : cmx_source
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                       clk_i = 1'h0, nrst_i = 1'h0, align_reset_i = 1'h0;
    logic                       ref_clk_i, vco_i, lock_indicator_o, locked_o;
    logic                       ref_run = 1'h0, vco_run = 1'h0, rprev = 1'h0;
    logic [cmx_pkg::DATA_W-1:0] data_i, sample_o;
    cmx_pkg::cmx_ctrl_t         ctrl_i = '0;
    cmx_pkg::cmx_ticks_t        ticks_o;
    int                         n_errors = 0, num_checks = 0, rises = 0, cyc = 0;
    cmx_source u_src (.clk_i, .ref_run_i(ref_run), .vco_run_i(vco_run), .ref_clk_o(ref_clk_i),
        .vco_o(vco_i), .data_o(data_i));
    cmx_clock_control DUT (.clk_i, .nrst_i, .ctrl_i, .ref_clk_i, .vco_i, .align_reset_i, .data_i,
        .lock_indicator_o, .locked_o, .ticks_o, .sample_o, .filter_hp_o(), .zero_stuff_o());
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        rises <= rises + int'(ref_clk_i && !rprev);
        rprev <= ref_clk_i;
        cyc   <= cyc + 1;
    end
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check
    task automatic wait_tick(input int b);
        int n = 0;
        do @(posedge clk_i); while (ticks_o[b] !== 1'h1 && ++n < 300);
    endtask : wait_tick
    task automatic t_bypass(input logic zs);
        int r0;
        ctrl_i        <= {1'h0, 2'h0, zs, zs};
        align_reset_i <= 1'h1;
        repeat (4) @(posedge clk_i);
        check("pin_forced", 1'h1, lock_indicator_o);
        align_reset_i <= 1'h0;
        ref_run       <= 1'h1;
        r0 = rises;
        wait_tick(2);
        check("pin_first_2x", 1'h0, lock_indicator_o);
        wait_tick(0);
        check("rises_to_first", 16'(2 + 2 * zs), 16'(rises - r0));
        r0 = rises;
        wait_tick(0);
        check("rises_between", 16'(2 + 2 * zs), 16'(rises - r0));
        check("pin_at_capture", 1'h1, lock_indicator_o);
        ref_run <= 1'h0;
    endtask : t_bypass
    task automatic t_presc();
        int t0;
        vco_run <= 1'h1;
        for (int s = 0; s < 4; s++) begin
            ctrl_i <= {1'h1, 2'(s), 2'h0};
            wait_tick(2);
            wait_tick(2);
            t0 = cyc;
            wait_tick(2);
            check("presc_gap", 16'(2 << s), 16'(cyc - t0));
        end
        vco_run <= 1'h0;
    endtask : t_presc
    task automatic t_unlock();
        int ones = 0;
        ref_run <= 1'h1;
        repeat (64) begin
            @(posedge clk_i);
            ones += int'(lock_indicator_o === 1'h1);
        end
        check("toggles", 1'h1, 16'(ones > 0 && ones < 64));
        check("unlocked", 1'h0, locked_o);
    endtask : t_unlock
    task automatic t_lock();
        int ones = 0;
        ctrl_i  <= {1'h1, 2'h0, 2'h0};
        vco_run <= 1'h1;
        ref_run <= 1'h1;
        repeat (120) @(posedge clk_i);
        // monitor samples the indicator several times before trusting lock
        repeat (8) begin
            @(posedge clk_i);
            ones += int'(lock_indicator_o === 1'h1);
        end
        check("lock_pin_high", 16'h0008, 16'(ones));
        check("locked", 1'h1, locked_o);
        vco_run <= 1'h0;
        ref_run <= 1'h0;
    endtask : t_lock
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'h1;
        t_bypass(1'h0);
        t_bypass(1'h1);
        t_presc();
        t_unlock();
        t_lock();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
